// >>> design/sfp_pin_if.sv
// serial flash pin interface: chip select, lanes, pause, reset, protection
//
// Operation
// [RULE_01] Chip select high deselects the device and floats every output.
// [RULE_02] While deselected the block reports low-power standby.
// [RULE_03] Serial input bits arriving with chip select high are ignored.
// [RULE_04] After reset no frame is accepted until chip select went high, then low.
// [RULE_05] Single-line input bits are sampled from line 0 on rising sck.
// [RULE_06] Single-line output bits change on line 1 at falling sck.
// [RULE_07] Dual and quad lanes are bidirectional, captured rising, driven falling.
// [RULE_08] Quad transfers use data_line_2 and data_line_3 as data lanes.
// [RULE_09] With write disable set and the protect pin low, status writes are refused.
// [RULE_10] Quad enable set turns off the protect function of data_line_2.
// [RULE_11] Line 3 is data with quad enable, else pause or reset by the select bit.
// [RULE_12] Pause low while selected freezes the sequence, which resumes on release.
// [RULE_13] Pause low while selected floats the output lines.
// [RULE_14] Reset low holds the block in reset with outputs floating.
// [RULE_15] The host avoids reset while a status write or array change runs.
// [RULE_16] Both idle sck polarities work alike: sample rising, drive falling.
// [RULE_17] Pause is inert when deselected; deselect during pause drops the sequence.
`timescale 1ns/10ps
`default_nettype none

module sfp_pin_if
  import sfp_pkg::*;
(
  // core clock and reset
  input  wire logic           core_clk,
  input  wire logic           rst,
  // link pins
  input  wire logic           sck,
  input  wire logic           cs_n,
  input  wire logic [3:0]     io_i,
  output logic      [3:0]     io_o,
  output logic      [3:0]     io_oe,
  // frame setup, taken only while deselected
  input  wire sfp_lane_type   lane_mode,
  input  wire logic           dir_out,
  input  wire logic           line3_function_select,
  // received bytes
  output logic                rx_valid,
  output logic      [7:0]     rx_data,
  // bytes to send
  input  wire logic           tx_valid,
  input  wire logic [7:0]     tx_data,
  output logic                tx_ready,
  // status register
  input  wire logic           sr_wr_valid,
  input  wire sfp_status_type sr_wr_data,
  output sfp_status_type      status,
  output logic                sr_wr_reject,
  // pin state
  output logic                standby,
  output logic                pause_active,
  output logic                hw_reset_active
);

  // core domain state
  logic [4:0]     sync1_q;
  logic [4:0]     sync1_d;
  logic [4:0]     sync2_q;
  logic [4:0]     sync2_d;
  logic           rx_seen_q;
  logic           rx_seen_d;
  logic           tk_seen_q;
  logic           tk_seen_d;
  logic [7:0]     rx_data_q;
  logic [7:0]     rx_data_d;
  logic           rx_valid_q;
  logic           rx_valid_d;
  logic [7:0]     tx_hold_q;
  logic [7:0]     tx_hold_d;
  logic           tx_full_q;
  logic           tx_full_d;
  sfp_status_type status_q;
  sfp_status_type status_d;
  logic           reject_q;
  logic           reject_d;
  sfp_cfg_type    cfg_q;
  sfp_cfg_type    cfg_d;
  // link domain state, rising edge
  logic [7:0]     in_sr_q;
  logic [7:0]     in_sr_d;
  logic [3:0]     in_cnt_q;
  logic [3:0]     in_cnt_d;
  logic [7:0]     rx_byte_q;
  logic [7:0]     rx_byte_d;
  logic           rx_tgl_q;
  logic           rx_tgl_d;
  logic           seen_rise_q;
  logic           seen_rise_d;
  // link domain state, falling edge
  logic [7:0]     out_sr_q;
  logic [7:0]     out_sr_d;
  logic [3:0]     out_cnt_q;
  logic [3:0]     out_cnt_d;
  logic           loaded_q;
  logic           loaded_d;
  logic           tk_tgl_q;
  logic           tk_tgl_d;

  logic           pause_fn;
  logic           reset_fn;
  logic           pause_low;
  logic           link_rst;
  logic [3:0]     step;
  logic [7:0]     cur_byte;
  logic [3:0]     lanes_in;
  logic           protect;

  assign pause_fn  = ~cfg_q.quad_io_enable & ~cfg_q.line3_function_select; // RULE_11
  assign reset_fn  = ~cfg_q.quad_io_enable & cfg_q.line3_function_select;  // RULE_11
  assign pause_low = pause_fn & ~io_i[3];
  // deselect, hardware reset or no arming clears all link state but the hand-off toggles
  assign link_rst  = cs_n | (reset_fn & ~io_i[3]) | ~cfg_q.armed; // RULE_03 RULE_14 RULE_17 RULE_04
  assign step      = sfp_step(cfg_q.lanes);
  assign cur_byte  = loaded_q ? out_sr_q : tx_hold_q;

  // capture lanes in the order of the active width
  always_comb
  begin
    case (cfg_q.lanes)
      SFP_LANE_DUAL: lanes_in = {2'h0, io_i[1:0]};        // RULE_07
      SFP_LANE_QUAD: lanes_in = io_i;                     // RULE_08
      default:       lanes_in = {3'h0, io_i[0]};          // RULE_05
    endcase
  end

  // rising edge: sampling, byte assembly
  always_comb
  begin
    in_sr_d     = in_sr_q;
    in_cnt_d    = in_cnt_q;
    rx_byte_d   = rx_byte_q;
    rx_tgl_d    = rx_tgl_q;
    seen_rise_d = seen_rise_q;
    if (!pause_low) // RULE_12
    begin
      seen_rise_d = 1'b1; // RULE_16
      if (!cfg_q.dir_out)
      begin
        case (cfg_q.lanes)
          SFP_LANE_DUAL: in_sr_d = {in_sr_q[5:0], lanes_in[1:0]};
          SFP_LANE_QUAD: in_sr_d = {in_sr_q[3:0], lanes_in};
          default:       in_sr_d = {in_sr_q[6:0], lanes_in[0]};
        endcase
        in_cnt_d = in_cnt_q + step;
        if (in_cnt_d == SFP_BYTE_BITS)
        begin
          in_cnt_d  = SFP_CNT_RST;
          rx_byte_d = in_sr_d;
          rx_tgl_d  = ~rx_tgl_q;
        end
      end
    end
  end

  always_ff @(posedge sck or posedge link_rst)
  begin
    if (link_rst)
    begin
      in_sr_q     <= SFP_BYTE_RST;
      in_cnt_q    <= SFP_CNT_RST;
      rx_byte_q   <= SFP_BYTE_RST;
      seen_rise_q <= 1'b0;
    end
    else
    begin
      in_sr_q     <= in_sr_d;
      in_cnt_q    <= in_cnt_d;
      rx_byte_q   <= rx_byte_d;
      seen_rise_q <= seen_rise_d;
    end
  end
  // hand-off toggles outlive deselect so the core sees no false event
  always_ff @(posedge sck or posedge rst)
  begin
    if (rst)
      rx_tgl_q <= 1'b0;
    else
      rx_tgl_q <= rx_tgl_d;
  end

  // falling edge: shift out; a fall before the first rise is skipped
  always_comb
  begin
    out_sr_d  = out_sr_q;
    out_cnt_d = out_cnt_q;
    loaded_d  = loaded_q;
    tk_tgl_d  = tk_tgl_q;
    if (!pause_low && seen_rise_q && cfg_q.dir_out) // RULE_06 RULE_16 RULE_12
    begin
      if (!loaded_q)
      begin
        loaded_d = 1'b1;
        tk_tgl_d = ~tk_tgl_q;
      end
      out_cnt_d = out_cnt_q + step;
      out_sr_d  = cur_byte << step;
      if (out_cnt_d == SFP_BYTE_BITS)
      begin
        out_cnt_d = SFP_CNT_RST;
        out_sr_d  = tx_hold_q;
        tk_tgl_d  = ~tk_tgl_d;
      end
    end
  end

  always_ff @(negedge sck or posedge link_rst)
  begin
    if (link_rst)
    begin
      out_sr_q  <= SFP_BYTE_RST;
      out_cnt_q <= SFP_CNT_RST;
      loaded_q  <= 1'b0;
    end
    else
    begin
      out_sr_q  <= out_sr_d;
      out_cnt_q <= out_cnt_d;
      loaded_q  <= loaded_d;
    end
  end
  always_ff @(negedge sck or posedge rst)
  begin
    if (rst)
      tk_tgl_q <= 1'b0;
    else
      tk_tgl_q <= tk_tgl_d;
  end

  // pin drive; floats when deselected, in reset or paused
  always_comb
  begin
    io_oe = 4'h0;
    case (cfg_q.lanes)
      SFP_LANE_DUAL: io_o = {2'h0, cur_byte[7:6]};       // RULE_07
      SFP_LANE_QUAD: io_o = cur_byte[7:4];               // RULE_08
      default:       io_o = {2'h0, cur_byte[7], 1'b0};   // RULE_06
    endcase
    if (!link_rst && !pause_low && cfg_q.dir_out) // RULE_01 RULE_13 RULE_14
    begin
      io_oe = sfp_oe(cfg_q.lanes);
    end
  end

  // core domain: synchronisers, byte hand-off, status register
  always_comb
  begin
    sync1_d    = {tk_tgl_q, rx_tgl_q, io_i[3], io_i[2], cs_n};
    sync2_d    = sync1_q;
    rx_seen_d  = sync2_q[SFP_SY_RX];
    tk_seen_d  = sync2_q[SFP_SY_TK];
    rx_data_d  = rx_data_q;
    rx_valid_d = 1'b0;
    tx_hold_d  = tx_hold_q;
    tx_full_d  = tx_full_q;
    status_d   = status_q;
    reject_d   = 1'b0;
    cfg_d      = cfg_q;
    protect    = status_q.status_write_disable & ~sync2_q[SFP_SY_L2]
                 & ~status_q.quad_io_enable; // RULE_09 RULE_10
    if (sync2_q[SFP_SY_RX] != rx_seen_q)
    begin
      rx_data_d  = rx_byte_q;
      rx_valid_d = 1'b1;
    end
    if (sync2_q[SFP_SY_TK] != tk_seen_q)
      tx_full_d = 1'b0;
    if (tx_valid && !tx_full_q)
    begin
      tx_hold_d = tx_data;
      tx_full_d = 1'b1;
    end
    if (sr_wr_valid)
    begin
      if (protect)
        reject_d = 1'b1; // RULE_09
      else
        status_d = sr_wr_data;
    end
    // setup changes only while deselected, so the link sees it stable
    if (sync2_q[SFP_SY_CS])
    begin
      cfg_d.armed                 = 1'b1; // RULE_04
      cfg_d.quad_io_enable        = status_q.quad_io_enable;
      cfg_d.line3_function_select = line3_function_select;
      cfg_d.dir_out               = dir_out;
      cfg_d.lanes                 = lane_mode;
      if (lane_mode == SFP_LANE_QUAD && !status_q.quad_io_enable)
        cfg_d.lanes = SFP_LANE_SINGLE;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync1_q    <= SFP_SYNC_RST;
      sync2_q    <= SFP_SYNC_RST;
      rx_seen_q  <= 1'b0;
      tk_seen_q  <= 1'b0;
      rx_data_q  <= SFP_BYTE_RST;
      rx_valid_q <= 1'b0;
      tx_hold_q  <= SFP_BYTE_RST;
      tx_full_q  <= 1'b0;
      status_q   <= SFP_STATUS_RST;
      reject_q   <= 1'b0;
      cfg_q      <= SFP_CFG_RST;
    end
    else
    begin
      sync1_q    <= sync1_d;
      sync2_q    <= sync2_d;
      rx_seen_q  <= rx_seen_d;
      tk_seen_q  <= tk_seen_d;
      rx_data_q  <= rx_data_d;
      rx_valid_q <= rx_valid_d;
      tx_hold_q  <= tx_hold_d;
      tx_full_q  <= tx_full_d;
      status_q   <= status_d;
      reject_q   <= reject_d;
      cfg_q      <= cfg_d;
    end
  end

  assign rx_valid        = rx_valid_q;
  assign rx_data         = rx_data_q;
  assign tx_ready        = ~tx_full_q;
  assign status          = status_q;
  assign sr_wr_reject    = reject_q;
  assign standby         = sync2_q[SFP_SY_CS]; // RULE_02
  assign pause_active    = ~sync2_q[SFP_SY_CS] & pause_fn
                           & ~sync2_q[SFP_SY_L3]; // RULE_17
  assign hw_reset_active = reset_fn & ~sync2_q[SFP_SY_L3]; // RULE_14

endmodule

`default_nettype wire

// >>> design/sfp_pkg.sv
// constants, types and helpers of the serial flash pin interface
package sfp_pkg;

  typedef enum logic [2:0]
  {
    SFP_LANE_SINGLE = 3'h1,
    SFP_LANE_DUAL   = 3'h2,
    SFP_LANE_QUAD   = 3'h4
  } sfp_lane_type;

  typedef struct packed
  {
    logic       status_write_disable;
    logic       quad_io_enable;
    logic [3:0] block_protect_bits;
  } sfp_status_type;

  // configuration frozen while selected, read by the sck domain
  typedef struct packed
  {
    logic         armed;
    logic         quad_io_enable;
    logic         line3_function_select;
    sfp_lane_type lanes;
    logic         dir_out;
  } sfp_cfg_type;

  localparam sfp_status_type SFP_STATUS_RST = 6'h00;
  localparam sfp_cfg_type    SFP_CFG_RST    = 7'h02;
  localparam logic [7:0]     SFP_BYTE_RST   = 8'h00;
  localparam logic [3:0]     SFP_CNT_RST    = 4'h0;
  localparam logic [3:0]     SFP_BYTE_BITS  = 4'h8;
  localparam logic [3:0]     SFP_STEP_SGL   = 4'h1;
  localparam logic [3:0]     SFP_STEP_DUAL  = 4'h2;
  localparam logic [3:0]     SFP_STEP_QUAD  = 4'h4;
  localparam logic [3:0]     SFP_OE_SGL     = 4'h2;
  localparam logic [3:0]     SFP_OE_DUAL    = 4'h3;
  localparam logic [3:0]     SFP_OE_QUAD    = 4'hf;
  // sync vector bits: cs_n, data_line_2, data_line_3, rx toggle, take toggle
  localparam int             SFP_SY_CS      = 0;
  localparam int             SFP_SY_L2      = 1;
  localparam int             SFP_SY_L3      = 2;
  localparam int             SFP_SY_RX      = 3;
  localparam int             SFP_SY_TK      = 4;
  // chip select sync starts low: only a real deselect may arm the link
  localparam logic [4:0]     SFP_SYNC_RST   = 5'h06;

  function automatic logic [3:0] sfp_step(input sfp_lane_type l);
    case (l)
      SFP_LANE_DUAL: sfp_step = SFP_STEP_DUAL;
      SFP_LANE_QUAD: sfp_step = SFP_STEP_QUAD;
      default:       sfp_step = SFP_STEP_SGL;
    endcase
  endfunction

  function automatic logic [3:0] sfp_oe(input sfp_lane_type l);
    case (l)
      SFP_LANE_DUAL: sfp_oe = SFP_OE_DUAL;
      SFP_LANE_QUAD: sfp_oe = SFP_OE_QUAD;
      default:       sfp_oe = SFP_OE_SGL;
    endcase
  endfunction

endpackage

// >>> verification/sfp_host_model.sv
// host-side model driving the serial flash link pins
`timescale 1ns/10ps
`default_nettype none
module sfp_host_model
(
  // link pins
  output var logic        sck,
  output var logic        cs_n,
  output var logic  [3:0] h_o,
  output var logic  [3:0] h_oe,
  input  wire logic [3:0] io
);
  // starts selected so power-up arming can be probed
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b0;
    h_o = 4'hf;
    h_oe = 4'hf;
  end

  task automatic pins(input logic [3:0] oe, input logic [3:0] o);
    h_oe = oe;
    h_o = o;
  endtask

  // sck parks at the idle polarity before chip select moves
  task automatic frame(input logic sel, input logic cpol);
    sck = cpol;
    #24;
    cs_n = !sel;
    #24;
  endtask

  // drive before the fall, capture at the rise
  task automatic shift(input int k, input int n, input logic [7:0] tx,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      if (k == 1) h_o[0] = tx[7];
      else if (k == 2) h_o[1:0] = tx[7:6];
      else h_o = tx[7:4];
      tx = tx << k;
      sck = 1'b0;
      #24;
      sck = 1'b1;
      rx = (k == 1) ? {rx[6:0], io[1]} :
           (k == 2) ? {rx[5:0], io[1:0]} : {rx[3:0], io};
      #24;
    end
  endtask
endmodule
`default_nettype wire

// >>> verification/sfp_pin_if_properties.sv
// port assertions of the serial flash pin interface
`timescale 1ns/10ps
`default_nettype none
module sfp_pin_if_properties
  import sfp_pkg::*;
(
  // clocks and reset
  input wire logic           core_clk,
  input wire logic           rst,
  input wire logic           sck,
  // pins
  input wire logic           cs_n,
  input wire logic [3:0]     io_i,
  input wire logic [3:0]     io_oe,
  // status and pin state
  input wire logic           sr_wr_valid,
  input wire sfp_status_type sr_wr_data,
  input wire sfp_status_type status,
  input wire logic           sr_wr_reject,
  input wire logic           standby,
  input wire logic           pause_active,
  input wire logic           hw_reset_active
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_desel_float: assert property
    (cs_n |-> io_oe == 4'h0)
    else $error("pins driven while deselected");
  a_standby_follow: assert property
    ($stable(cs_n) [*3] |-> standby == cs_n)
    else $error("standby does not follow chip select");
  a_pause_inert: assert property
    (cs_n [*4] |-> !pause_active)
    else $error("pause seen while deselected");
  a_wr_refuse: assert property
    ((!io_i[2]) [*3] ##0 (sr_wr_valid && status.status_write_disable
      && !status.quad_io_enable) |=> sr_wr_reject && $stable(status))
    else $error("protected status write not refused");
  a_wr_open: assert property
    (sr_wr_valid && !status.status_write_disable
      |=> !sr_wr_reject && status == $past(sr_wr_data))
    else $error("open status write not taken");
  a_qe_open: assert property
    (sr_wr_valid && status.quad_io_enable |=> status == $past(sr_wr_data))
    else $error("status write refused with quad enable");
  a_pause_float: assert property
    (pause_active && !io_i[3] && !cs_n |-> io_oe == 4'h0)
    else $error("pins driven during pause");
  a_reset_float: assert property
    (hw_reset_active && !io_i[3] |-> io_oe == 4'h0)
    else $error("pins driven during hardware reset");
  a_line3_data: assert property
    (io_oe[3] |-> !pause_active && !hw_reset_active)
    else $error("line 3 is data and control at once");

  c_reject: cover property (sr_wr_reject);
  c_pause: cover property (pause_active);
  c_hwrst: cover property (hw_reset_active);
endmodule

bind sfp_pin_if sfp_pin_if_properties u_props
(
  .core_clk, .rst, .sck, .cs_n, .io_i, .io_oe, .sr_wr_valid, .sr_wr_data,
  .status, .sr_wr_reject, .standby, .pause_active, .hw_reset_active
);
`default_nettype wire

// >>> verification/sfp_pin_if_tb_top.sv
// self-checking bench of the serial flash pin interface
`timescale 1ns/10ps
`default_nettype none
module sfp_pin_if_tb_top;
  import sfp_pkg::*;
  logic           core_clk = 1'b0;
  logic           rst = 1'b1;
  logic           sck, cs_n, rx_valid, tx_ready, sr_wr_reject;
  logic           standby, pause_active, hw_reset_active;
  logic [3:0]     io_o, io_oe, h_o, h_oe, io_i;
  logic [3:0]     flt = 4'h5;
  sfp_lane_type   lane_mode = SFP_LANE_SINGLE;
  logic           dir_out = 1'b0, line3_function_select = 1'b0;
  logic           tx_valid = 1'b0, sr_wr_valid = 1'b0;
  logic [7:0]     tx_data = 8'h00, rx_data;
  sfp_status_type sr_wr_data = 6'h00, status;
  int             bad_count = 0, check_count = 0, rx_n = 0;

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) flt <= ~flt;
  always @(posedge core_clk) if (rx_valid) rx_n++;
  // undriven lines show a changing pattern
  assign io_i = (io_oe & io_o) | (~io_oe & h_oe & h_o) | (~io_oe & ~h_oe & flt);

  sfp_pin_if u_dut
  (
    .core_clk, .rst, .sck, .cs_n, .io_i, .io_o, .io_oe, .lane_mode, .dir_out,
    .line3_function_select, .rx_valid, .rx_data, .tx_valid, .tx_data,
    .tx_ready, .sr_wr_valid, .sr_wr_data, .status, .sr_wr_reject, .standby,
    .pause_active, .hw_reset_active
  );
  sfp_host_model u_host (.sck, .cs_n, .h_o, .h_oe, .io(io_i));

  task automatic check(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [5:0] d, exp, input logic rj);
    @(negedge core_clk);
    sr_wr_valid = 1'b1;
    sr_wr_data = d;
    @(negedge core_clk);
    sr_wr_valid = 1'b0;
    check("reject", 8'(sr_wr_reject), 8'(rj));
    check("status", 8'(status), 8'(exp));
  endtask

  task automatic load(input logic [7:0] b);
    @(negedge core_clk);
    tx_valid = 1'b1;
    tx_data = b;
    @(negedge core_clk);
    tx_valid = 1'b0;
    check("tx_ready", 8'(tx_ready), 8'h00);
  endtask

  task automatic t_arm;
    logic [7:0] r;
    u_host.shift(1, 8, 8'h5a, r);
    u_host.frame(1'b0, 1'b0);
    u_host.shift(1, 8, 8'h5a, r);
    cyc(8);
    check("rx_unarmed", 8'(rx_n), 8'h00);
    check("standby", 8'(standby), 8'h01);
    check("status_rst", 8'(status), 8'h00);
  endtask

  // one byte on k lanes; d set lets the block send b
  task automatic xfer(input int k, input logic cpol, d, input logic [7:0] b);
    logic [7:0] r;
    logic [3:0] oe;
    oe = (k == 1) ? 4'h2 : (k == 2) ? 4'h3 : 4'hf;
    @(negedge core_clk);
    dir_out = d;
    lane_mode = (k == 1) ? SFP_LANE_SINGLE :
                (k == 2) ? SFP_LANE_DUAL : SFP_LANE_QUAD;
    if (d) load(b);
    u_host.pins(d ? ~oe : 4'hf, 4'hf);
    cyc(4);
    rx_n = 0;
    u_host.frame(1'b1, cpol);
    check("oe", 8'(io_oe), d ? 8'(oe) : 8'h00);
    u_host.shift(k, 8 / k, d ? 8'h00 : b, r);
    u_host.frame(1'b0, cpol);
    cyc(8);
    check("oe_off", 8'(io_oe), 8'h00);
    if (d) check("tx_free", 8'(tx_ready), 8'h01);
    if (d) check("sent", r, b);
    else check("rx", {rx_data[7:1], rx_n == 1 ? rx_data[0] : 1'bx}, b);
  endtask

  task automatic t_pause;
    logic [7:0] a, c;
    @(negedge core_clk);
    dir_out = 1'b1;
    lane_mode = SFP_LANE_SINGLE;
    load(8'h96);
    u_host.pins(4'hd, 4'hf);
    cyc(4);
    u_host.frame(1'b1, 1'b0);
    u_host.shift(1, 4, 8'h00, a);
    u_host.pins(4'hd, 4'h7);
    cyc(4);
    check("paused", 8'(pause_active), 8'h01);
    check("oe_pause", 8'(io_oe), 8'h00);
    u_host.shift(1, 3, 8'h00, c);
    u_host.pins(4'hd, 4'hf);
    #24;
    u_host.shift(1, 4, 8'h00, c);
    check("resumed", {a[3:0], c[3:0]}, 8'h96);
    u_host.pins(4'hd, 4'h7);
    #24;
    u_host.frame(1'b0, 1'b0);
    cyc(6);
    check("pause_desel", 8'(pause_active), 8'h00);
  endtask

  task automatic t_hwrst;
    line3_function_select = 1'b1;
    u_host.pins(4'hd, 4'hf);
    cyc(4);
    u_host.frame(1'b1, 1'b1);
    // no status write is in flight here
    u_host.pins(4'hd, 4'h7);
    cyc(4);
    check("hw_rst", 8'(hw_reset_active), 8'h01);
    check("oe_rst", 8'(io_oe), 8'h00);
    check("no_pause", 8'(pause_active), 8'h00);
    u_host.pins(4'hd, 4'hf);
    u_host.frame(1'b0, 1'b1);
  endtask

  // the whole sequence needs about 6 us
  initial
  begin
    #200000;
    bad_count++;
    summarize;
  end

  initial
  begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_arm;
    wr(6'h25, 6'h25, 1'b0);
    u_host.pins(4'hf, 4'hb);
    cyc(3);
    wr(6'h0a, 6'h25, 1'b1);
    u_host.pins(4'hf, 4'hf);
    cyc(3);
    wr(6'h30, 6'h30, 1'b0);
    u_host.pins(4'hf, 4'hb);
    cyc(3);
    wr(6'h3f, 6'h3f, 1'b0);
    wr(6'h10, 6'h10, 1'b0);
    xfer(1, 1'b0, 1'b0, 8'ha5);
    xfer(1, 1'b1, 1'b0, 8'h3c);
    xfer(1, 1'b0, 1'b1, 8'hc3);
    xfer(1, 1'b1, 1'b1, 8'h81);
    xfer(2, 1'b0, 1'b0, 8'h6d);
    xfer(2, 1'b0, 1'b1, 8'hb2);
    xfer(4, 1'b1, 1'b0, 8'he1);
    xfer(4, 1'b0, 1'b1, 8'h1e);
    u_host.pins(4'hf, 4'hb);
    cyc(3);
    wr(6'h00, 6'h00, 1'b0);
    t_pause;
    t_hwrst;
    summarize;
  end
endmodule
`default_nettype wire
